// ---- tb/multiphase_vr_sequencer_tb.sv ----
// Bench: registers, start-up, phase rotation and link of the sequencer.
// Assumes the host model answers on the link and raises power-ok.
`timescale 1ns/100ps
`include "vr_seq_defines.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
	num_errors++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
`define WAITN(c, m) for (n = 0; (c) && n < m; n++) @(negedge clk_sys_i); \
	if (c) num_errors++;
module multiphase_vr_sequencer_tb;
	import vr_seq_pkg::*;
	logic clk_sys_i, rst_n_i, psel, penable, pwrite, pready, pslverr, err;
	logic supply_ok_i, enable_i, power_ok_input_i, slew_select_strap_i;
	logic serial_voltage_clock_i, serial_voltage_data_i, core_ramp_hit_i;
	logic power_state_low0_n_i, power_state_low1_n_i, bridge_ramp_hit_i;
	logic core_first_phase_sense_i, core_second_phase_sense_i;
	logic core_third_phase_sense_i, bridge_first_phase_sense_i;
	logic bridge_second_phase_sense_i, core_power_good_o, bridge_power_good_o;
	logic core_ramp_restart_o, bridge_ramp_restart_o, serial_telemetry_o;
	logic voltage_change_on_fly_o, tel_last = 1'b0;
	logic [1:0] bridge_window_reached_i, bridge_pwm_o, bridge_low_side_gate_o;
	logic [1:0] core_compensation_strap_i, bridge_compensation_strap_i;
	logic [2:0] core_window_reached_i, core_zero_cross_i, core_pwm_o, seen;
	logic [2:0] core_low_side_gate_o;
	logic [7:0] paddr, current_level_i, core_voltage_code_o;
	logic [7:0] bridge_voltage_code_o, last_code;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] modes [3] = '{2'b11, 2'b01, 2'b00};
	seq_state_type seq_state_o;
	int num_errors, n_checks, cycles, n_voltage_change_on_fly, n_tel, n, cnt [3];
	// Bridge phases follow the core stimulus
	assign bridge_ramp_hit_i = core_ramp_hit_i;
	assign bridge_window_reached_i = core_window_reached_i[1:0];
	multiphase_vr_sequencer #(.STARTUP_DELAY_CYC(40)) dut (.*);
	vr_host_model host (
		.clk_i      (clk_sys_i),
		.core_pg_i  (core_power_good_o),
		.bridge_pg_i(bridge_power_good_o),
		.link_clk_o (serial_voltage_clock_i),
		.link_data_o(serial_voltage_data_i),
		.pok_o      (power_ok_input_i)
	);
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// Event counters and timeout, sampled away from the launching edge
	always @(negedge clk_sys_i) begin
		cycles++;
		n_voltage_change_on_fly += int'(voltage_change_on_fly_o === 1'b1);
		n_tel += int'(serial_telemetry_o !== tel_last);
		tel_last = serial_telemetry_o;
		if (cycles == 40000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// One APB transfer; request held until pready is seen
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge clk_sys_i);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
		@(posedge clk_sys_i);
		penable <= 1'b1;
		do @(posedge clk_sys_i); while (pready !== 1'b1);
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	// One master clock: record the phase that fired, then end its pulse
	task automatic pulse(input logic de);
		@(posedge clk_sys_i);
		{core_ramp_hit_i, core_window_reached_i, core_zero_cross_i} <= 7'h40;
		repeat (10) @(negedge clk_sys_i);
		seen = core_pwm_o;
		for (int k = 0; k < 3; k++) cnt[k] += int'(seen[k]);
		@(posedge clk_sys_i);
		{core_ramp_hit_i, core_window_reached_i} <= {1'b0, seen};
		repeat (6) @(negedge clk_sys_i);
		`CHK("pwm end", 3'h0, core_pwm_o)
		if (de) begin
			`CHK("low gate on", seen, core_low_side_gate_o)
			@(posedge clk_sys_i);
			core_zero_cross_i <= 3'h7;
			repeat (6) @(negedge clk_sys_i);
			`CHK("low gate off", 3'h0, core_low_side_gate_o)
		end
	endtask
	initial begin
		{rst_n_i, psel, penable, pwrite, supply_ok_i, core_ramp_hit_i} = '0;
		{core_first_phase_sense_i, core_second_phase_sense_i} = 2'b00;
		{core_third_phase_sense_i, bridge_first_phase_sense_i} = 2'b00;
		{bridge_second_phase_sense_i, paddr, pwdata} = '0;
		{core_window_reached_i, core_zero_cross_i} = 6'h00;
		{enable_i, power_state_low0_n_i, power_state_low1_n_i} = 3'h7;
		{slew_select_strap_i, core_compensation_strap_i} = 3'b110;
		{bridge_compensation_strap_i, current_level_i} = 10'h1A5;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		apb(1'b0, `REG_CTRL_ADDR, 32'h0);
		`CHK("ctrl", `CTRL_RESET_VAL, rd)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 2'b10, {err, rd[0]})
		`CHK("held idle", ST_IDLE, seq_state_o)
		supply_ok_i <= 1'b1;
		`WAITN(seq_state_o !== ST_DELAY, 9)
		`CHK("code off", `CODE_OFF, core_voltage_code_o)
		`WAITN(seq_state_o === ST_DELAY, 99)
		`CHK("delay", 40, n)
		`WAITN(core_voltage_code_o === `CODE_OFF, 999)
		last_code = core_voltage_code_o;
		`WAITN(core_voltage_code_o === last_code, 999)
		`CHK("step", `STEP_FAST_CYC, n)
		@(posedge clk_sys_i);
		host.send_frame(9'h020);
		`WAITN(power_ok_input_i !== 1'b1, 20000)
		`CHK("boot code", `BOOT_CODE0, core_voltage_code_o)
		`CHK("br code", `BOOT_CODE0, bridge_voltage_code_o)
		`CHK("early cmd", 0, n_voltage_change_on_fly)
		apb(1'b0, `REG_STRAP_ADDR, 32'h0);
		`CHK("straps", 8'hB7, rd[7:0])
		foreach (modes[m]) begin
			@(posedge clk_sys_i);
			{power_state_low0_n_i, power_state_low1_n_i} <= modes[m];
			cnt = '{0, 0, 0};
			repeat (6) pulse(m == 2);
			for (int k = 0; k < 3; k++) begin
				n = (k < 3 - m) ? 6 / (3 - m) : 0;
				`CHK("phases", n, cnt[k])
			end
		end
		@(posedge clk_sys_i);
		host.send_frame(9'h060);
		host.send_frame(9'h070);
		host.send_frame(9'h150);
		repeat (4) @(posedge clk_sys_i);
		apb(1'b0, `REG_CODE_ADDR, 32'h0);
		`CHK("targets", 16'h5070, {rd[31:24], rd[15:8]})
		`CHK("rise events", 2, n_voltage_change_on_fly)
		`CHK("telemetry", 1'b1, n_tel > 0)
		enable_i <= 1'b0;
		`WAITN(seq_state_o !== ST_IDLE, 9)
		@(negedge clk_sys_i);
		`CHK("off", 4'h0, {core_power_good_o, core_pwm_o})
		summarize();
	end
endmodule

// ---- tb/vr_host_model.sv ----
// Processor side of the link: boot pattern, power-ok and command frames.
// Assumes the bench clock; a link half period is six system cycles.
`timescale 1ns/100ps
module vr_host_model (
	input  wire logic clk_i,
	input  wire logic core_pg_i,
	input  wire logic bridge_pg_i,
	output logic      link_clk_o,
	output logic      link_data_o,
	output logic      pok_o
);
	// Pins rest at boot pattern 00 until the first frame
	initial {link_clk_o, link_data_o, pok_o} = 3'b000;
	// Power-ok only once both outputs report good
	always @(posedge clk_i) pok_o <= core_pg_i & bridge_pg_i;
	// Frame MSB first; the link clock stands still outside frames
	task automatic send_frame(input logic [8:0] frame);
		for (int i = 8; i >= 0; i--) begin
			link_data_o <= frame[i];
			repeat (6) @(posedge clk_i);
			link_clk_o <= 1'b1;
			repeat (6) @(posedge clk_i);
			link_clk_o <= 1'b0;
		end
		link_data_o <= ~frame[0]; // Stale data must not look valid
		@(posedge clk_i);
	endtask
endmodule

// ---- verilog/multiphase_vr_sequencer.sv ----
// Digital sequencer of a dual-output multiphase buck regulator: phase
// clock distribution, pulse control, start-up, soft-start and serial link.
// Assumes analog comparators, straps and link pins arrive asynchronously;
// registers are reached over APB with zero wait beyond one access cycle.
//
// Overview of operation
// [RQ1] Three phases: clocks rotate 1-2-3, 120 degrees
// [RQ2] Two phases: clocks alternate 1-2, 180 degrees
// [RQ3] One phase: every master clock goes phase one
// [RQ4] Ramp hit: one master pulse, ramp restarts
// [RQ5] Pulse starts on clock, ends at window
// [RQ6] Diode emulation: low gate off at zero-cross
// [RQ7] Sense strapped high: phase skipped, no pulses
// [RQ8] First phase strapped: whole output stays off
// [RQ9] Inputs ignored until power-on-reset released
// [RQ10] Rising enable starts; low enable keeps off
// [RQ11] Wait 8ms reading straps before soft-start
// [RQ12] Enable latches boot code into DAC target
// [RQ13] Straps captured during delay, held until restart
// [RQ14] Soft-start steps DAC at strap slew rate
// [RQ15] Power-good rises when soft-start ramp ends
// [RQ16] Commands accepted only after power-ok high
// [RQ17] Processor holds boot code static before enable
// [RQ18] New code moves DAC; rise flags event
// [RQ19] Telemetry shifts out with the link clock
// [RQ20] Power-state pins pick three, two, one-DE
// [RQ21] Sequencer visits enabled phases ascending, wrapping
// [RQ22] Off, delayed or reset outputs stay inactive
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "vr_seq_defines.svh"

module multiphase_vr_sequencer #(
	parameter int STARTUP_DELAY_CYC = `STARTUP_DELAY_CYC
) (
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        supply_ok_i,
	input  wire logic                        enable_i,
	input  wire logic                        serial_voltage_clock_i,
	input  wire logic                        serial_voltage_data_i,
	input  wire logic                        power_ok_input_i,
	input  wire logic                        power_state_low0_n_i,
	input  wire logic                        power_state_low1_n_i,
	input  wire logic                        core_first_phase_sense_i,
	input  wire logic                        core_second_phase_sense_i,
	input  wire logic                        core_third_phase_sense_i,
	input  wire logic                        bridge_first_phase_sense_i,
	input  wire logic                        bridge_second_phase_sense_i,
	input  wire logic                        core_ramp_hit_i,
	input  wire logic                        bridge_ramp_hit_i,
	input  wire logic [2:0]                  core_window_reached_i,
	input  wire logic [1:0]                  bridge_window_reached_i,
	input  wire logic [2:0]                  core_zero_cross_i,
	input  wire logic                        slew_select_strap_i,
	input  wire logic [1:0]                  core_compensation_strap_i,
	input  wire logic [1:0]                  bridge_compensation_strap_i,
	input  wire logic [7:0]                  current_level_i,
	output logic                             core_ramp_restart_o,
	output logic                             bridge_ramp_restart_o,
	output logic [2:0]                       core_pwm_o,
	output logic [1:0]                       bridge_pwm_o,
	output logic [2:0]                       core_low_side_gate_o,
	output logic [1:0]                       bridge_low_side_gate_o,
	output logic [7:0]                       core_voltage_code_o,
	output logic [7:0]                       bridge_voltage_code_o,
	output logic                             core_power_good_o,
	output logic                             bridge_power_good_o,
	output logic                             voltage_change_on_fly_o,
	output logic                             serial_telemetry_o,
	output vr_seq_pkg::seq_state_type        seq_state_o
);
	import vr_seq_pkg::*;

	localparam int SYNC_W = 27;
	localparam int DLY_W  = $clog2(STARTUP_DELAY_CYC + 1);
	localparam logic [7:0] STEP_FAST = 8'(`STEP_FAST_CYC - 1);
	localparam logic [7:0] STEP_SLOW = 8'(`STEP_SLOW_CYC - 1);
	localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(STARTUP_DELAY_CYC - 1);

	// Next enabled phase after the last one, ascending with wrap
	function automatic logic [2:0] next_phase(input logic [2:0] last,
	                                          input logic [2:0] mask);
		logic [2:0] r;
		logic [2:0] c;
		r = 3'h0;
		c = last;
		for (int k = 0; k < 3; k++) begin
			c = {c[1:0], c[2]};
			if (r == 3'h0 && (c & mask) != 3'h0)
				r = c;
		end
		return r;
	endfunction

	// One code step toward the target
	function automatic logic [7:0] step_to(input logic [7:0] code,
	                                       input logic [7:0] target);
		if (code < target)
			return code + 8'h01;
		else if (code > target)
			return code - 8'h01;
		return code;
	endfunction

	// Two-stage synchroniser for every pin from outside the clock domain except current_level_i, which is used as it arrives
	logic [SYNC_W-1:0] async_w;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	assign async_w = {supply_ok_i, enable_i, serial_voltage_clock_i,
		serial_voltage_data_i, power_ok_input_i, power_state_low0_n_i,
		power_state_low1_n_i, core_third_phase_sense_i,
		core_second_phase_sense_i, core_first_phase_sense_i,
		bridge_second_phase_sense_i, bridge_first_phase_sense_i,
		core_ramp_hit_i, bridge_ramp_hit_i, core_window_reached_i,
		bridge_window_reached_i, core_zero_cross_i, slew_select_strap_i,
		core_compensation_strap_i, bridge_compensation_strap_i};
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= async_w;
			sync2_reg <= sync1_reg;
		end
	end

	logic       s_por, s_en, s_svc, s_svd, s_power_ok_input, s_ps0_n, s_ps1_n;
	logic [2:0] s_core_sense, s_core_win, s_core_zc;
	logic [1:0] s_br_sense, s_br_win, s_core_comp, s_br_comp;
	logic       s_core_ramp, s_br_ramp, s_slew;
	assign {s_por, s_en, s_svc, s_svd, s_power_ok_input, s_ps0_n, s_ps1_n,
		s_core_sense, s_br_sense, s_core_ramp, s_br_ramp, s_core_win,
		s_br_win, s_core_zc, s_slew, s_core_comp, s_br_comp} = sync2_reg;

	// Previous values for edge detection, taken from the second stage
	logic en_prev_reg, svc_prev_reg, core_ramp_prev_reg, br_ramp_prev_reg;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_prev_reg        <= 1'b0;
			svc_prev_reg       <= 1'b0;
			core_ramp_prev_reg <= 1'b0;
			br_ramp_prev_reg   <= 1'b0;
		end else begin
			en_prev_reg        <= s_por & s_en; // RQ9
			svc_prev_reg       <= s_svc;
			core_ramp_prev_reg <= s_core_ramp;
			br_ramp_prev_reg   <= s_br_ramp;
		end
	end

	// Start-up state and latched configuration
	seq_state_type    state_reg;
	seq_state_type    state_next;
	logic [DLY_W-1:0] dly_cnt_reg;
	logic [7:0]       boot_code_reg, step_cnt_reg;
	logic [7:0]       core_code_reg, core_target_reg;
	logic [7:0]       br_code_reg, br_target_reg;
	logic [2:0]       core_present_reg;
	logic [1:0]       br_present_reg, core_comp_reg, br_comp_reg;
	logic             slew_fast_reg, core_pg_reg, br_pg_reg;
	logic [31:0]      ctrl_reg;

	logic por_ok_w, en_rise_w, dly_done_w, step_tick_w;
	logic core_on_w, br_on_w, core_run_w, br_run_w, soft_done_w;
	logic [7:0] boot_pin_code_w;
	assign por_ok_w    = s_por & s_en; // RQ9 RQ10
	assign en_rise_w   = por_ok_w & ~en_prev_reg; // RQ10
	assign dly_done_w  = dly_cnt_reg == DLY_LAST;
	assign step_tick_w = step_cnt_reg == (slew_fast_reg ? STEP_FAST
		: STEP_SLOW);
	assign core_on_w   = state_reg inside {ST_SOFT, ST_RUN};
	assign br_on_w     = core_on_w;
	assign core_run_w  = core_on_w & core_present_reg[0]; // RQ8 RQ22
	assign br_run_w    = br_on_w & br_present_reg[0]; // RQ8 RQ22
	assign soft_done_w = (!core_present_reg[0] ||
		core_code_reg == core_target_reg) &&
		(!br_present_reg[0] || br_code_reg == br_target_reg);
	assign boot_pin_code_w = ({s_svc, s_svd} == 2'b00) ? `BOOT_CODE0 :
		({s_svc, s_svd} == 2'b01) ? `BOOT_CODE1 :
		({s_svc, s_svd} == 2'b10) ? `BOOT_CODE2 : `BOOT_CODE3;

	// Start-up sequence: any loss of supply or enable drops to idle
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:  if (en_rise_w) state_next = ST_DELAY; // RQ10
			ST_DELAY: if (dly_done_w) state_next = ST_SOFT; // RQ11
			ST_SOFT:  if (soft_done_w) state_next = ST_RUN; // RQ14
			ST_RUN:   state_next = ST_RUN;
		endcase
		if (!por_ok_w)
			state_next = ST_IDLE; // RQ10 RQ22
	end

	// Serial command receiver, gated by power-ok
	logic [8:0] cmd_shift_reg;
	logic [3:0] cmd_cnt_reg;
	logic       cmd_ok_w, svc_rise_w, svc_fall_w, cmd_done_w;
	logic [8:0] cmd_word_w;
	logic       cmd_core_w, cmd_br_w, voltage_change_on_fly_w;
	assign svc_rise_w = s_svc & ~svc_prev_reg;
	assign svc_fall_w = ~s_svc & svc_prev_reg;
	assign cmd_ok_w   = state_reg == ST_RUN && s_power_ok_input; // RQ16
	assign cmd_done_w = cmd_ok_w && svc_rise_w &&
		cmd_cnt_reg == 4'(`CMD_BITS - 1);
	assign cmd_word_w = {cmd_shift_reg[7:0], s_svd};
	assign cmd_core_w = cmd_done_w && !cmd_word_w[8] && core_present_reg[0];
	assign cmd_br_w   = cmd_done_w && cmd_word_w[8] && br_present_reg[0];
	assign voltage_change_on_fly_w     = (cmd_core_w && cmd_word_w[7:0] < core_target_reg) ||
		(cmd_br_w && cmd_word_w[7:0] < br_target_reg); // RQ18

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmd_shift_reg <= 9'h000;
			cmd_cnt_reg   <= 4'h0;
		end else if (!cmd_ok_w) begin
			cmd_cnt_reg   <= 4'h0; // RQ16
		end else if (svc_rise_w) begin
			cmd_shift_reg <= cmd_word_w;
			cmd_cnt_reg   <= cmd_done_w ? 4'h0 : cmd_cnt_reg + 4'h1;
		end
	end

	// Sequence state, delay timer and captured straps
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg        <= ST_IDLE;
			dly_cnt_reg      <= '0;
			boot_code_reg    <= `CODE_OFF;
			core_present_reg <= 3'h0;
			br_present_reg   <= 2'h0;
			core_comp_reg    <= 2'h0;
			br_comp_reg      <= 2'h0;
			slew_fast_reg    <= 1'b0;
		end else begin
			state_reg   <= state_next;
			dly_cnt_reg <= (state_reg == ST_DELAY) ? dly_cnt_reg + 1'b1
				: '0; // RQ11
			if (en_rise_w && state_reg == ST_IDLE)
				boot_code_reg <= boot_pin_code_w; // RQ12
			// Straps keep their start-up value until the next start-up
			if (state_reg == ST_DELAY) begin
				core_present_reg <= ~s_core_sense; // RQ7 RQ13
				br_present_reg   <= ~s_br_sense; // RQ7 RQ13
				core_comp_reg    <= s_core_comp; // RQ13
				br_comp_reg      <= s_br_comp; // RQ13
				slew_fast_reg    <= s_slew; // RQ13
			end
		end
	end

	// DAC codes, targets and power-good
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			step_cnt_reg    <= 8'h00;
			core_code_reg   <= `CODE_OFF;
			br_code_reg     <= `CODE_OFF;
			core_target_reg <= `CODE_OFF;
			br_target_reg   <= `CODE_OFF;
			core_pg_reg     <= 1'b0;
			br_pg_reg       <= 1'b0;
		end else begin
			step_cnt_reg <= (!core_on_w || step_tick_w) ? 8'h00
				: step_cnt_reg + 8'h01; // RQ14
			if (state_reg == ST_DELAY) begin
				core_target_reg <= boot_code_reg; // RQ12
				br_target_reg   <= boot_code_reg;
			end else if (cmd_core_w) begin
				core_target_reg <= cmd_word_w[7:0]; // RQ18
			end else if (cmd_br_w) begin
				br_target_reg   <= cmd_word_w[7:0]; // RQ18
			end
			if (!core_run_w)
				core_code_reg <= `CODE_OFF;
			else if (step_tick_w)
				core_code_reg <= step_to(core_code_reg, core_target_reg);
			if (!br_run_w)
				br_code_reg <= `CODE_OFF;
			else if (step_tick_w)
				br_code_reg <= step_to(br_code_reg, br_target_reg);
			// Stays high through later voltage moves once the ramp ended
			core_pg_reg <= core_run_w &&
				(core_pg_reg || core_code_reg == core_target_reg); // RQ15
			br_pg_reg   <= br_run_w &&
				(br_pg_reg || br_code_reg == br_target_reg); // RQ15
		end
	end

	// Core mode from the power-state pins; 10 is taken as two-phase
	logic [2:0] core_mode_mask_w, core_mask_w;
	logic [1:0] br_mask_w;
	logic       core_de_w;
	assign core_mode_mask_w = ({s_ps0_n, s_ps1_n} == 2'b11) ? 3'b111 :
		({s_ps0_n, s_ps1_n} == 2'b00) ? 3'b001 : 3'b011; // RQ20
	assign core_de_w   = {s_ps0_n, s_ps1_n} == 2'b00; // RQ20
	assign core_mask_w = core_present_reg & core_mode_mask_w &
		{3{core_run_w}}; // RQ7 RQ22
	assign br_mask_w   = br_present_reg & {2{br_run_w}}; // RQ7 RQ22

	// Master clock and phase sequencer
	logic       core_ramp_ev_w, br_ramp_ev_w;
	logic [2:0] core_last_reg, core_fire_reg, br_last_reg, br_fire_reg;
	logic [2:0] core_pick_w, br_pick_w;
	assign core_ramp_ev_w = s_core_ramp & ~core_ramp_prev_reg;
	assign br_ramp_ev_w   = s_br_ramp & ~br_ramp_prev_reg;
	assign core_pick_w = next_phase(core_last_reg, core_mask_w);
	assign br_pick_w   = next_phase(br_last_reg, {1'b0, br_mask_w});

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core_ramp_restart_o   <= 1'b0;
			bridge_ramp_restart_o <= 1'b0;
			core_last_reg <= 3'b100;
			br_last_reg   <= 3'b100;
			core_fire_reg <= 3'h0;
			br_fire_reg   <= 3'h0;
		end else begin
			core_ramp_restart_o   <= core_ramp_ev_w & core_run_w; // RQ4
			bridge_ramp_restart_o <= br_ramp_ev_w & br_run_w; // RQ4
			core_fire_reg <= core_ramp_restart_o ? core_pick_w
				: 3'h0; // RQ1 RQ2 RQ3
			br_fire_reg   <= bridge_ramp_restart_o ? br_pick_w : 3'h0;
			if (core_ramp_restart_o && core_pick_w != 3'h0)
				core_last_reg <= core_pick_w; // RQ21
			if (bridge_ramp_restart_o && br_pick_w != 3'h0)
				br_last_reg <= br_pick_w; // RQ21
		end
	end

	// Phase slaves: channels 0-2 core, 3-4 bridge
	logic [4:0] ch_fire_w, ch_allow_w, ch_win_w, ch_zc_w, ch_de_w;
	logic [4:0] pwm_reg, low_side_gate_reg;
	assign ch_fire_w  = {br_fire_reg[1:0], core_fire_reg};
	assign ch_allow_w = {br_mask_w, core_mask_w};
	assign ch_win_w   = {s_br_win, s_core_win};
	assign ch_zc_w    = {2'b00, s_core_zc};
	assign ch_de_w    = {4'h0, core_de_w};

	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_slave
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					pwm_reg[g]   <= 1'b0;
					low_side_gate_reg[g] <= 1'b0;
				end else if (!ch_allow_w[g]) begin
					pwm_reg[g]   <= 1'b0; // RQ7 RQ22
					low_side_gate_reg[g] <= 1'b0;
				end else if (ch_fire_w[g]) begin
					pwm_reg[g]   <= 1'b1; // RQ5
					low_side_gate_reg[g] <= 1'b0;
				end else if (pwm_reg[g]) begin
					pwm_reg[g]   <= ~ch_win_w[g]; // RQ5
					low_side_gate_reg[g] <= ch_win_w[g];
				end else if (ch_de_w[g] && ch_zc_w[g]) begin
					low_side_gate_reg[g] <= 1'b0; // RQ6
				end
			end
		end
	endgenerate
	assign core_pwm_o             = pwm_reg[2:0];
	assign bridge_pwm_o           = pwm_reg[4:3];
	assign core_low_side_gate_o   = low_side_gate_reg[2:0];
	assign bridge_low_side_gate_o = low_side_gate_reg[4:3];

	// Telemetry shifter; changes on the falling link clock edge
	logic [15:0] telem_reg;
	logic [3:0]  telem_cnt_reg;
	logic        telem_on_w;
	assign telem_on_w = cmd_ok_w && ctrl_reg[`CTRL_TELEM_EN_BIT];
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			telem_reg          <= 16'h0000;
			telem_cnt_reg      <= 4'h0;
			serial_telemetry_o <= 1'b0;
			voltage_change_on_fly_o <= 1'b0;
		end else begin
			voltage_change_on_fly_o <= voltage_change_on_fly_w; // RQ18
			if (!telem_on_w) begin
				telem_cnt_reg      <= 4'h0;
				serial_telemetry_o <= 1'b0;
			end else if (svc_fall_w) begin
				telem_reg <= (telem_cnt_reg == 4'h0) ?
					{current_level_i, core_code_reg} << 1
					: telem_reg << 1; // RQ19
				serial_telemetry_o <= (telem_cnt_reg == 4'h0) ?
					current_level_i[7] : telem_reg[15]; // RQ19
				telem_cnt_reg <= telem_cnt_reg + 4'h1;
			end
		end
	end

	// APB slave: read data prepared in setup, answered in access
	logic setup_w, hit_w, wr_ctrl_w;
	logic [31:0] rd_mux_w;
	assign setup_w  = psel & ~penable;
	assign hit_w    = paddr inside {`REG_CTRL_ADDR, `REG_STATUS_ADDR,
		`REG_CODE_ADDR, `REG_STRAP_ADDR};
	assign wr_ctrl_w = psel & penable & pready & pwrite &
		(paddr == `REG_CTRL_ADDR);
	assign rd_mux_w =
		(paddr == `REG_CTRL_ADDR)   ? ctrl_reg :
		(paddr == `REG_STATUS_ADDR) ? {19'h0, br_present_reg,
			core_mask_w, s_ps0_n, s_ps1_n, br_pg_reg, core_pg_reg,
			state_reg} :
		(paddr == `REG_CODE_ADDR)   ? {br_target_reg, br_code_reg,
			core_target_reg, core_code_reg} :
		(paddr == `REG_STRAP_ADDR)  ? {24'h0, slew_fast_reg, br_comp_reg,
			core_comp_reg, core_present_reg} : 32'h0000_0000;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= `CTRL_RESET_VAL;
			prdata   <= 32'h0000_0000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
		end else begin
			pready  <= setup_w;
			pslverr <= setup_w & ~hit_w;
			prdata  <= (setup_w && !pwrite) ? rd_mux_w : 32'h0000_0000;
			if (wr_ctrl_w)
				ctrl_reg <= pwdata;
		end
	end

	// Published status, straight from flip-flops
	assign core_voltage_code_o   = core_code_reg;
	assign bridge_voltage_code_o = br_code_reg;
	assign core_power_good_o     = core_pg_reg;
	assign bridge_power_good_o   = br_pg_reg;
	assign seq_state_o           = state_reg;

	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	chk_three_phase_rot: assert property ( // RQ1
		core_ramp_restart_o && core_mask_w == 3'b111 &&
		core_last_reg == 3'b100 |=> core_fire_reg == 3'b001)
		else $error("three-phase rotation broken");
	chk_two_phase_alt: assert property ( // RQ2
		core_ramp_restart_o && core_mask_w == 3'b011 &&
		core_last_reg == 3'b001 |=> core_fire_reg == 3'b010)
		else $error("two-phase alternation broken");
	chk_one_phase_route: assert property ( // RQ3
		core_ramp_restart_o && core_mask_w == 3'b001 |=>
		core_fire_reg == 3'b001)
		else $error("single phase not routed to phase one");
	chk_master_restart: assert property ( // RQ4
		core_ramp_ev_w && core_run_w |=> core_ramp_restart_o ##1
		!core_ramp_restart_o)
		else $error("master clock not a one-shot");
	chk_pwm_start: assert property ( // RQ5
		core_fire_reg[0] && core_mask_w[0] |=> core_pwm_o[0])
		else $error("pulse did not start on phase clock");
	chk_de_low_side_gate_off: assert property ( // RQ6
		core_de_w && s_core_zc[0] && !pwm_reg[0] && !core_fire_reg[0]
		&& core_mask_w[0] |=> !core_low_side_gate_o[0])
		else $error("low gate stayed on after zero cross");
	chk_absent_silent: assert property ( // RQ7
		!core_present_reg[2] |-> ##1 !core_pwm_o[2] ##1 !core_pwm_o[2])
		else $error("absent phase produced pulses");
	chk_bridge_off: assert property ( // RQ8
		!br_present_reg[0] |=> !bridge_power_good_o && !bridge_pwm_o[0])
		else $error("disabled output active");
	chk_delay_holds: assert property ( // RQ11
		state_reg == ST_DELAY && por_ok_w && !dly_done_w |=>
		state_reg == ST_DELAY)
		else $error("soft-start began before delay ended");
	chk_core_power_good_end: assert property ( // RQ15
		$rose(core_power_good_o) |-> $past(core_code_reg ==
		core_target_reg) && $past(core_run_w))
		else $error("power-good before ramp end");
	chk_cmd_gated: assert property ( // RQ16
		state_reg == ST_RUN && !s_power_ok_input |=> $stable(core_target_reg)
		&& $stable(br_target_reg))
		else $error("command taken without power-ok");
	chk_voltage_change_on_fly_rise: assert property ( // RQ18
		voltage_change_on_fly_o |-> $past(voltage_change_on_fly_w) &&
		core_target_reg <= $past(core_target_reg))
		else $error("transition event without voltage rise");
	chk_idle_quiet: assert property ( // RQ22
		!por_ok_w |=> ##1 pwm_reg == 5'h00 && !core_power_good_o)
		else $error("outputs active while off");

	cov_three_phase: cover property (core_fire_reg == 3'b100 &&
		core_mask_w == 3'b111);
	cov_soft_to_run: cover property (state_reg == ST_SOFT ##1
		state_reg == ST_RUN);
	cov_voltage_change_on_fly: cover property (voltage_change_on_fly_o);
	cov_de_zero_cross: cover property (core_de_w && $fell(low_side_gate_reg[0]));
endmodule

// ---- verilog/vr_seq_defines.svh ----
// Constants of the multiphase regulator sequencer: register map, field
// positions, reset values and timing counts.
// Assumes a 250 MHz system clock and a 32-bit APB register bus.
`ifndef VR_SEQ_DEFINES_SVH
`define VR_SEQ_DEFINES_SVH

// Register byte addresses
`define REG_CTRL_ADDR    8'h00
`define REG_STATUS_ADDR  8'h04
`define REG_CODE_ADDR    8'h08
`define REG_STRAP_ADDR   8'h0C

// Control register fields and reset value
`define CTRL_TELEM_EN_BIT 0
`define CTRL_RESET_VAL    32'h0000_0001

// Clock and timing figures
`define CLK_MHZ             250
`define STARTUP_DELAY_MS    8
`define SLEW_FAST_MV_PER_US 20
`define SLEW_SLOW_MV_PER_US 10
`define VID_STEP_UV         6250
`define STARTUP_DELAY_CYC   (`STARTUP_DELAY_MS * 1000 * `CLK_MHZ)
`define STEP_FAST_CYC \
	((`VID_STEP_UV * `CLK_MHZ) / (`SLEW_FAST_MV_PER_US * 1000))
`define STEP_SLOW_CYC \
	((`VID_STEP_UV * `CLK_MHZ) / (`SLEW_SLOW_MV_PER_US * 1000))

// Voltage codes: a lower code is a higher voltage
`define CODE_OFF   8'hFF
`define BOOT_CODE0 8'h68
`define BOOT_CODE1 8'h58
`define BOOT_CODE2 8'h48
`define BOOT_CODE3 8'h38

// Serial link framing
`define CMD_BITS   9
`define TELEM_BITS 16

`endif

// ---- verilog/vr_seq_pkg.sv ----
// Types shared by the multiphase regulator sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package vr_seq_pkg;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_DELAY = 4'b0010,
		ST_SOFT  = 4'b0100,
		ST_RUN   = 4'b1000
	} seq_state_type;
endpackage
